// ===== src/adcts_converter_subsystem_clock_gen.sv
// Subsystem clock enable: system clock or synchronised burst oscillator
`default_nettype none
module adcts_converter_subsystem_clock_gen
   import adcts_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic arst_n_i,
   // Source selection
   input  wire logic burst_clock_enable_i,
   input  wire logic burst_osc_i,
   // Subsystem clock enable
   output logic      converter_subsystem_clock_en_o
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic [4:0] gap_reg;
   logic [4:0] gap_next;
   logic       converter_subsystem_clock_en_reg;
   logic       converter_subsystem_clock_en_next;
   logic       edge_ok;

   localparam logic [4:0] GAP_MIN = 5'(BURST_MIN_GAP_CYC - 1);

   // Edges closer than the rate limit are dropped, so a fast source cannot overrun
   always_comb begin
      sync_next = {sync_reg[1:0], burst_osc_i};
      edge_ok   = sync_reg[1] && !sync_reg[2] && (gap_reg >= GAP_MIN);
      gap_next  = edge_ok ? 5'h00 : ((gap_reg >= GAP_MIN) ? gap_reg : gap_reg + 5'h01);
      converter_subsystem_clock_en_next = burst_clock_enable_i ? edge_ok : 1'b1;
   end

   // State registers
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_reg    <= 3'h0;
         gap_reg     <= 5'h00;
         converter_subsystem_clock_en_reg <= 1'b0;
      end else begin
         sync_reg    <= sync_next;
         gap_reg     <= gap_next;
         converter_subsystem_clock_en_reg <= converter_subsystem_clock_en_next;
      end
   end

   assign converter_subsystem_clock_en_o = converter_subsystem_clock_en_reg;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   // First edge after reset still shows the cleared flop, so it is left out
   sysclk_source_a: assert property (
      $past(arst_n_i) && $past(!burst_clock_enable_i) |-> converter_subsystem_clock_en_reg)
      else $error("subsystem enable missing in system clock mode");
   burst_rate_a: assert property (edge_ok |=> !edge_ok [*7])
      else $error("burst edges accepted faster than maximum rate");
endmodule // adcts_converter_subsystem_clock_gen
`default_nettype wire

// ===== src/adcts_pkg.sv
// Shared constants and types for the converter track and convert sequencer
`default_nettype none
package adcts_pkg;
   // Clock rates
   localparam int CORE_CLK_PERIOD_NS = 5;
   localparam int CORE_CLK_MHZ       = 1000 / CORE_CLK_PERIOD_NS;
   localparam int BURST_MAX_MHZ      = 25;
   // Least core cycles between two accepted burst edges, rounded up
   localparam int BURST_MIN_GAP_CYC  = (CORE_CLK_MHZ + BURST_MAX_MHZ - 1) / BURST_MAX_MHZ;

   // Field widths
   localparam int MODE_W = 2;
   localparam int TK_W   = 4;
   localparam int DIV_W  = 5;
   localparam int CNT_W  = 5;

   // Sequence counts
   localparam logic [CNT_W-1:0] TRK_EXTRA_CONVERTER_SUBSYSTEM_CLOCK = 5'h02;
   localparam logic [CNT_W-1:0] SAR_CYCLES     = 5'h0D;
   localparam logic [CNT_W-1:0] CONV_EXTRA_CONVERTER_SUBSYSTEM_CLOCK = 5'h02;
   localparam logic [DIV_W-1:0] DIV_RESET      = 5'h1F;

   // Tracking mode encodings
   localparam logic [MODE_W-1:0] MODE_PRE  = 2'h0;
   localparam logic [MODE_W-1:0] MODE_POST = 2'h1;
   localparam logic [MODE_W-1:0] MODE_PRE2 = 2'h2;
   localparam logic [MODE_W-1:0] MODE_DUAL = 2'h3;

   // Controller states, Gray coded along idle, track, convert
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_TRACK = 2'h1,
      ST_CONV  = 2'h3
   } adcts_state_e;

   // Conversion phases
   typedef enum logic [1:0] {
      PH_START  = 2'h0,
      PH_SAR    = 2'h1,
      PH_FINISH = 2'h3
   } adcts_phase_e;

   // Modes whose start opens a timed tracking window
   function automatic logic has_window(input logic [MODE_W-1:0] mode);
      return (mode == MODE_POST) || (mode == MODE_DUAL);
   endfunction
endpackage
`default_nettype wire

// ===== src/adcts_sar_div.sv
// Conversion clock enable divided from the subsystem clock enable
`default_nettype none
module adcts_sar_div
   import adcts_pkg::*;
(
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             arst_n_i,
   // Control
   input  wire logic             converter_subsystem_clock_en_i,
   input  wire logic             restart_i,
   input  wire logic [DIV_W-1:0] div_i,
   // Conversion clock enable
   output logic                  sar_en_o
);
   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] cnt_next;
   logic             sar_en_reg;
   logic             sar_en_next;

   // One pulse every div_i+1 subsystem cycles
   always_comb begin
      cnt_next    = cnt_reg;
      sar_en_next = 1'b0;
      if (restart_i) begin
         cnt_next = '0;
      end else if (converter_subsystem_clock_en_i) begin
         if (cnt_reg == div_i) begin
            cnt_next    = '0;
            sar_en_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 5'h01;
         end
      end
   end

   // State registers
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg    <= '0;
         sar_en_reg <= 1'b0;
      end else begin
         cnt_reg    <= cnt_next;
         sar_en_reg <= sar_en_next;
      end
   end

   assign sar_en_o = sar_en_reg;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   sar_ratio_a: assert property (
      sar_en_reg |-> $past(converter_subsystem_clock_en_i) && !$past(restart_i) && $past(cnt_reg) == $past(div_i))
      else $error("conversion clock pulse off the divide ratio");
endmodule // adcts_sar_div
`default_nettype wire

// ===== src/adcts_sequencer.sv
// Track and convert sequencer for the successive-approximation converter
`default_nettype none
module adcts_sequencer
   import adcts_pkg::*;
(
   // Clock and reset
   input  wire logic                       core_clk_i,
   input  wire logic                       arst_n_i,
   // Configuration
   input  wire logic [adcts_pkg::MODE_W-1:0] tracking_mode_select_i,
   input  wire logic [adcts_pkg::TK_W-1:0]   tracking_time_setting_i,
   input  wire logic [adcts_pkg::DIV_W-1:0]  conversion_clock_divider_i,
   input  wire logic                       burst_clock_enable_i,
   // Burst oscillator pin
   input  wire logic                       burst_osc_i,
   // Control
   input  wire logic                       conv_start_i,
   input  wire logic                       sw_track_i,
   // Analog side and status
   output logic                            sample_switch_o,
   output logic                            sar_clk_en_o,
   output logic                            conv_active_o,
   output logic                            conv_done_o,
   output logic [1:0]                      fsm_state_o
);
   import adcts_pkg::*;

   adcts_state_e     state_reg;
   adcts_state_e     state_next;
   adcts_phase_e     phase_reg;
   adcts_phase_e     phase_next;
   logic             win_reg;
   logic             win_next;
   logic [CNT_W-1:0] trk_cnt_reg;
   logic [CNT_W-1:0] trk_cnt_next;
   logic [CNT_W-1:0] sar_cnt_reg;
   logic [CNT_W-1:0] sar_cnt_next;
   logic [MODE_W-1:0] mode_reg;
   logic [MODE_W-1:0] mode_next;
   logic             done_reg;
   logic             done_next;
   logic             switch_reg;
   logic             sar_out_reg;
   logic             converter_subsystem_clock_en;
   logic             sar_en;
   logic             sar_restart;
   logic             accept_start;
   logic             pre_mode;
   logic             rest_track;
   // Output flops and shared decodes
   logic             switch_next;
   logic             sar_out_next;
   logic             active_reg;
   logic             active_next;
   logic             in_sar;

   // Subsystem clock enable
   adcts_converter_subsystem_clock_gen u_converter_subsystem_clock (
      .core_clk_i           (core_clk_i),
      .arst_n_i             (arst_n_i),
      .burst_clock_enable_i (burst_clock_enable_i),
      .burst_osc_i          (burst_osc_i),
      .converter_subsystem_clock_en_o            (converter_subsystem_clock_en)
   );

   // Divider runs only through the successive-approximation phase
   assign in_sar      = (state_reg == ST_CONV) && (phase_reg == PH_SAR);
   assign sar_restart = !in_sar;

   adcts_sar_div u_div (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .converter_subsystem_clock_en_i  (converter_subsystem_clock_en),
      .restart_i  (sar_restart),
      .div_i      (conversion_clock_divider_i),
      .sar_en_o   (sar_en)
   );

   // Start decode: ignored while a window or conversion is already running
   assign pre_mode     = !has_window(tracking_mode_select_i);
   assign accept_start = conv_start_i &&
                         ((state_reg == ST_IDLE) || ((state_reg == ST_TRACK) && !win_reg));
   // Resting state after a conversion follows the mode latched at start
   assign rest_track   = (mode_reg == MODE_DUAL) ||
                         (!has_window(mode_reg) && sw_track_i);

   // Sequencer next state
   always_comb begin
      state_next   = state_reg;
      phase_next   = phase_reg;
      win_next     = win_reg;
      trk_cnt_next = trk_cnt_reg;
      sar_cnt_next = sar_cnt_reg;
      mode_next    = mode_reg;
      done_next    = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            // Software owns tracking in pre-tracking mode
            if (pre_mode && sw_track_i) begin
               state_next = ST_TRACK;
            end else if (tracking_mode_select_i == MODE_DUAL) begin
               state_next = ST_TRACK;
            end
         end
         ST_TRACK: begin
            if (win_reg) begin
               if (converter_subsystem_clock_en) begin
                  if (trk_cnt_reg == 5'h01) begin
                     state_next = ST_CONV;
                     phase_next = PH_START;
                     win_next   = 1'b0;
                  end else begin
                     trk_cnt_next = trk_cnt_reg - 5'h01;
                  end
               end
            end else if (pre_mode ? !sw_track_i
                                  : (tracking_mode_select_i == MODE_POST)) begin
               state_next = ST_IDLE;
            end
         end
         ST_CONV: begin
            unique case (phase_reg)
               PH_START: begin
                  // One subsystem cycle to open the conversion
                  sar_cnt_next = '0;
                  if (converter_subsystem_clock_en) begin
                     phase_next = PH_SAR;
                  end
               end
               PH_SAR: begin
                  if (sar_en) begin
                     sar_cnt_next = sar_cnt_reg + 5'h01;
                     if (sar_cnt_reg == SAR_CYCLES - 5'h01) begin
                        phase_next = PH_FINISH;
                     end
                  end
               end
               PH_FINISH: begin
                  // One subsystem cycle to close it, then rest per mode
                  if (converter_subsystem_clock_en) begin
                     done_next  = 1'b1;
                     state_next = rest_track ? ST_TRACK : ST_IDLE;
                     phase_next = PH_START;
                  end
               end
               default: phase_next = PH_START;
            endcase
         end
         default: state_next = ST_IDLE;
      endcase
      // A convert start overrides the resting behaviour above
      if (accept_start) begin
         mode_next = tracking_mode_select_i;
         if (pre_mode) begin
            state_next = ST_CONV;
            phase_next = PH_START;
            win_next   = 1'b0;
         end else begin
            state_next   = ST_TRACK;
            win_next     = 1'b1;
            trk_cnt_next = 5'(tracking_time_setting_i) + TRK_EXTRA_CONVERTER_SUBSYSTEM_CLOCK;
         end
      end
   end

   // Switch and active next values follow the next state, so those two flops line up with it
   always_comb begin
      switch_next  = (state_next == ST_TRACK);
      active_next  = (state_next == ST_CONV);
      // Divider pulse forwarded only while the SAR phase runs
      sar_out_next = sar_en && in_sar;
   end

   // Sequencer registers; switch and active outputs decoded from next state so they align with it
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg   <= ST_IDLE;
         phase_reg   <= PH_START;
         win_reg     <= 1'b0;
         trk_cnt_reg <= '0;
         sar_cnt_reg <= '0;
         mode_reg    <= MODE_PRE;
         done_reg    <= 1'b0;
         switch_reg  <= 1'b0;
         sar_out_reg <= 1'b0;
         active_reg  <= 1'b0;
      end else begin
         state_reg   <= state_next;
         phase_reg   <= phase_next;
         win_reg     <= win_next;
         trk_cnt_reg <= trk_cnt_next;
         sar_cnt_reg <= sar_cnt_next;
         mode_reg    <= mode_next;
         done_reg    <= done_next;
         switch_reg  <= switch_next;
         sar_out_reg <= sar_out_next;
         active_reg  <= active_next;
      end
   end

   // Outputs straight from flops
   assign sample_switch_o = switch_reg;
   assign sar_clk_en_o    = sar_out_reg;
   assign conv_active_o   = active_reg;
   assign conv_done_o     = done_reg;
   assign fsm_state_o     = state_reg;

   // Checking helpers: subsystem cycles inside the window and around the SAR phase
   logic [CNT_W-1:0] chk_win_reg;
   logic [CNT_W-1:0] chk_win_next;
   logic [TK_W-1:0]  chk_tk_reg;
   logic [TK_W-1:0]  chk_tk_next;
   logic [CNT_W-1:0] chk_edge_reg;
   logic [CNT_W-1:0] chk_edge_next;

   // Helper next values; a take restarts every count
   always_comb begin
      chk_win_next  = chk_win_reg;
      chk_tk_next   = chk_tk_reg;
      chk_edge_next = chk_edge_reg;
      if (accept_start) begin
         chk_win_next  = '0;
         chk_tk_next   = tracking_time_setting_i;
         chk_edge_next = '0;
      end else if (converter_subsystem_clock_en) begin
         if (win_reg) begin
            chk_win_next = chk_win_reg + 5'h01;
         end
         // Start and finish phases are the two extra subsystem cycles
         if ((state_reg == ST_CONV) && !in_sar) begin
            chk_edge_next = chk_edge_reg + 5'h01;
         end
      end
   end

   // Helper registers
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         chk_win_reg  <= '0;
         chk_tk_reg   <= '0;
         chk_edge_reg <= '0;
      end else begin
         chk_win_reg  <= chk_win_next;
         chk_tk_reg   <= chk_tk_next;
         chk_edge_reg <= chk_edge_next;
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_window_end;
      (state_reg == ST_TRACK) && win_reg ##1 (state_reg == ST_CONV);
   endsequence
   sequence s_finish;
      (state_reg == ST_CONV) && (phase_reg == PH_FINISH) ##1 done_reg;
   endsequence

   // Mode checks
   state_legal_a: assert property (state_reg inside {ST_IDLE, ST_TRACK, ST_CONV})
      else $error("controller in no legal state");
   post_window_a: assert property (
      accept_start && tracking_mode_select_i == MODE_POST |=> state_reg == ST_TRACK && win_reg)
      else $error("post-tracking start did not open window");
   post_hiz_a: assert property (s_finish |-> mode_reg != MODE_POST || !sample_switch_o)
      else $error("input tracked after post-tracking conversion");
   dual_window_a: assert property (
      accept_start && tracking_mode_select_i == MODE_DUAL |=> win_reg ##[1:600] state_reg == ST_CONV)
      else $error("dual-tracking window did not lead to conversion");
   dual_track_a: assert property (s_finish |-> mode_reg != MODE_DUAL || sample_switch_o)
      else $error("dual-tracking not tracking after conversion");
   pre_direct_a: assert property (
      accept_start && pre_mode |=> state_reg == ST_CONV && !sample_switch_o)
      else $error("pre-tracking start did not convert at once");
   pre_soft_a: assert property (
      state_reg == ST_IDLE && pre_mode && sw_track_i && !conv_start_i
      |=> state_reg == ST_TRACK && sample_switch_o)
      else $error("software tracking request not followed");

   // Timing checks; window and start/finish cycles held against helper counters, conversion length against sar_cnt_reg
   win_len_a: assert property (
      s_window_end |-> chk_win_reg == 5'(chk_tk_reg) + TRK_EXTRA_CONVERTER_SUBSYSTEM_CLOCK)
      else $error("tracking window length wrong");
   conv_len_a: assert property (s_finish |-> $past(sar_cnt_reg) == SAR_CYCLES)
      else $error("conversion did not take thirteen clocks");
   conv_converter_subsystem_clock_a: assert property (s_finish |-> chk_edge_reg == CONV_EXTRA_CONVERTER_SUBSYSTEM_CLOCK)
      else $error("conversion start and finish cycles wrong");

   // Output and handshake checks
   sar_gate_a: assert property (sar_clk_en_o |-> conv_active_o)
      else $error("conversion clock outside a conversion");
   switch_conv_a: assert property (conv_active_o |-> !sample_switch_o)
      else $error("input tracked while converting");
   refuse_busy_a: assert property (
      conv_start_i && in_sar |=> state_reg == ST_CONV && phase_reg != PH_START)
      else $error("convert start taken during a conversion");
   done_pulse_a: assert property (
      done_reg |=> !done_reg && (state_reg != ST_CONV || $past(accept_start)))
      else $error("done not a single pulse");
endmodule // adcts_sequencer
`default_nettype wire

// ===== test/adc_track_convert_sequencer_tb_top.sv
// Self-checking bench for the track and convert sequencer
`default_nettype none
module adc_track_convert_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import adcts_pkg::*;
   // Bench signals
   logic       clk;
   logic       rst_n;
   logic [1:0] mode;
   logic [3:0] tk;
   logic [4:0] dv;
   logic       burst;
   logic       start;
   logic       sw;
   logic       osc;
   logic       sw_o;
   logic       sar_o;
   logic       act_o;
   logic       done_o;
   logic [1:0] st_o;
   logic [7:0] mticks;
   int         n_errors;
   int         n_checks;
   int         seed;
   int         t_id;

   // 200 MHz core clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   adcts_sequencer u_dut (
      .core_clk_i                 (clk),
      .arst_n_i                   (rst_n),
      .tracking_mode_select_i     (mode),
      .tracking_time_setting_i    (tk),
      .conversion_clock_divider_i (dv),
      .burst_clock_enable_i       (burst),
      .burst_osc_i                (osc),
      .conv_start_i               (start),
      .sw_track_i                 (sw),
      .sample_switch_o            (sw_o),
      .sar_clk_en_o               (sar_o),
      .conv_active_o              (act_o),
      .conv_done_o                (done_o),
      .fsm_state_o                (st_o)
   );

   adcts_core_model u_core (
      .core_clk_i   (clk),
      .arst_n_i     (rst_n),
      .osc_run_i    (burst),
      .sar_clk_en_i (sar_o),
      .conv_done_i  (done_o),
      .burst_osc_o  (osc),
      .last_ticks_o (mticks)
   );

   // Value compare, four-state exact
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Range compare for spans that depend on clock phase
   task automatic cmp_rng(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Window length in subsystem cycles; only modes 01 and 11 open one
   function automatic int exp_trk(input logic [1:0] m, input logic [3:0] k);
      return m[0] ? int'(k) + int'(TRK_EXTRA_CONVERTER_SUBSYSTEM_CLOCK) : 0;
   endfunction

   // Rest level of the switch after a conversion
   function automatic logic exp_rest(input logic [1:0] m, input logic s);
      return (m == 2'h3) || (!m[0] && s);
   endfunction

   // State code legal and the converting flag in step, every cycle
   always @(posedge clk) begin
      #1;
      if (rst_n === 1'b1) begin
         cmp(st_o === 2'h0 || st_o === 2'h1 || st_o === 2'h3, 1'b1);
         cmp(act_o, st_o === 2'h3);
      end
   end

   // One conversion; intr fires refused starts in the window and mid-conversion
   task automatic run(input logic [1:0] m, input logic [3:0] k, input logic [4:0] d,
                      input logic b, input logic s, input logic intr);
      int   trk;
      int   cnv;
      int   ticks;
      int   last;
      int   bad;
      int   per;
      int   dn;
      logic swbad;
      mode = m;
      tk = k;
      dv = d;
      burst = b;
      sw = s;
      trk = 0;
      cnv = 0;
      ticks = 0;
      last = 0;
      bad = 0;
      dn = 0;
      swbad = 1'b0;
      per = (int'(d) + 1) * (b ? BURST_MIN_GAP_CYC : 1);
      // Room for the synchroniser to fill after a source change
      repeat (6) @(posedge clk);
      #1;
      if (!m[0])
         cmp({st_o, sw_o}, {1'b0, s, s});
      start = 1'b1;
      @(posedge clk);
      #1;
      start = 1'b0;
      cmp(st_o, m[0] ? 2'h1 : 2'h3);
      for (int i = 0; i < 6000 && dn == 0; i++) begin
         if (st_o === 2'h1 && cnv == 0) begin
            trk++;
            swbad |= (sw_o !== 1'b1);
         end
         if (st_o === 2'h3) begin
            cnv++;
            swbad |= (sw_o !== 1'b0);
         end
         if (sar_o === 1'b1) begin
            if (ticks > 0)
               bad += b ? int'(i - last < per) : int'(i - last != per);
            ticks++;
            last = i;
         end
         start = intr && (cnv == 3 || (trk == 1 && cnv == 0));
         if (done_o === 1'b1)
            dn = 1;
         else begin
            @(posedge clk);
            #1;
         end
      end
      cmp(dn, 1);
      cmp(ticks, SAR_CYCLES);
      cmp(bad, 0);
      cmp(swbad, 1'b0);
      if (!b) begin
         cmp(trk, exp_trk(m, k));
         cmp_rng(cnv, 13 * (int'(d) + 1) + 2, 13 * (int'(d) + 1) + 3);
      end else if (m[0]) begin
         cmp_rng(trk, (exp_trk(m, k) - 1) * 8, (exp_trk(m, k) + 1) * 12);
      end
      @(posedge clk);
      #1;
      cmp(done_o, 1'b0);
      cmp(mticks, SAR_CYCLES);
      cmp({st_o, sw_o}, {1'b0, {2{exp_rest(m, s)}}});
      repeat (3) @(posedge clk);
      #1;
      cmp(act_o, 1'b0);
      $display("test %0d done", t_id);
      t_id++;
   endtask

   // Hang guard, far beyond the longest expected run
   initial begin
      #250_000;
      n_errors++;
      $display("watchdog expired");
      stop_test;
   end

   // Reset, corner runs over every mode code, then a random mix
   initial begin
      logic [31:0] r;
      seed = 30515;
      n_errors = 0;
      n_checks = 0;
      t_id = 0;
      rst_n = 1'b0;
      mode = 2'h0;
      tk = 4'h0;
      dv = 5'h00;
      burst = 1'b0;
      start = 1'b0;
      sw = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      cmp({sw_o, sar_o, act_o, done_o, st_o}, 6'h00);
      rst_n = 1'b1;
      for (int j = 0; j < 8; j++) begin
         run(j[1:0], j[2] ? 4'hF : 4'h0, {3'h0, j[2], 1'b0}, j[2], j[0], j[1]);
      end
      run(2'h1, 4'h7, 5'h1F, 1'b0, 1'b0, 1'b1);
      for (int j = 0; j < 12; j++) begin
         r = $random(seed);
         run(r[1:0], r[5:2], r[11] ? {3'h0, r[7:6]} : r[10:6], r[11], r[12], r[13]);
      end
      stop_test;
   end
endmodule // adc_track_convert_sequencer_tb_top
`default_nettype wire

// ===== test/adcts_core_model.sv
// Behavioural model of the burst oscillator and the converter core
`default_nettype none
module adcts_core_model (
   // Clock, reset and oscillator control
   input  wire logic       core_clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       osc_run_i,
   // Converter side of the sequencer
   input  wire logic       sar_clk_en_i,
   input  wire logic       conv_done_i,
   // Oscillator pin and step count of the last conversion
   output logic            burst_osc_o,
   output logic [7:0]      last_ticks_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tick_reg;

   // 44 ns period stays under the 25 MHz ceiling; odd phase to the core clock
   initial begin
      burst_osc_o = 1'b0;
      #3;
      forever begin
         #22 burst_osc_o = osc_run_i ? ~burst_osc_o : 1'b0;
      end
   end

   // Counts SAR steps, snapshot taken when the conversion completes
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tick_reg     <= 8'h00;
         last_ticks_o <= 8'h00;
      end else if (conv_done_i) begin
         last_ticks_o <= tick_reg + {7'h00, sar_clk_en_i};
         tick_reg     <= 8'h00;
      end else if (sar_clk_en_i) begin
         tick_reg <= tick_reg + 8'h01;
      end
   end
endmodule // adcts_core_model
`default_nettype wire
